/* include/silp_regs.svh */
// Register offsets, field positions, reset values and timing counts for the
// interrupt and low-power control block. Definitions only.
`ifndef SILP_REGS_SVH
`define SILP_REGS_SVH

`define SILP_OFF_FLAGS_LOW 8'h00
`define SILP_OFF_FLAGS_HIGH 8'h04
`define SILP_OFF_FLAGS_SPARE 8'h08
`define SILP_OFF_BREAK_STATE 8'h0C
`define SILP_OFF_BREAK_FLAG_CTRL 8'h10
`define SILP_OFF_OPTIONS 8'h14
`define SILP_OFF_ENABLES 8'h18
`define SILP_OFF_STATUS 8'h1C

`define SILP_BIT_BREAK_EXITED_LOWPOWER_FLAG 1
`define SILP_BIT_BREAK_CLEAR_ENABLE 0
`define SILP_BIT_SHORT_RECOVERY_OPTION 0
`define SILP_BIT_WATCHDOG_DISABLE_OPTION 1

`define SILP_NUM_SRC 17
`define SILP_ENABLES_RST 17'h1FFFF
`define SILP_REC_LONG_XCLK 13'h1000
`define SILP_REC_SHORT_XCLK 13'h0020

`endif

/* include/silp_pkg.sv */
// Types shared by the interrupt and low-power control block.
// Assumes the offsets and counts live in silp_regs.svh.
package silp_pkg;

  typedef enum logic [1:0] {
    SILP_RUN,
    SILP_WAIT,
    SILP_STOP,
    SILP_RECOVER
  } silp_mode_t;

  typedef struct packed {
    silp_mode_t mode;
    logic [12:0] rec_cnt;
    logic rec_is_brk;
    logic [2:0] xclk_sync;
    logic [16:0] enables;
    logic break_clear_enable;
    logic break_exited_lowpower_flag;
    logic short_recovery_option;
    logic watchdog_disable_option;
    logic [3:0] latched_vec;
    logic latched_valid;
    logic [1:0] aw_got;
    logic [31:0] wdata;
    logic [7:0] awaddr;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic [11:0] flags;
    logic cpu_clk_en;
    logic sys_clk_en;
    logic xclk_en;
    logic irq_req;
    logic clear_mask;
    logic brk_vec;
    logic wdog_run;
    logic flag_clear_ok;
  } silp_state_t;

endpackage : silp_pkg

/* core/silp_ctrl.sv */
// Interrupt prioritisation, status flags, break-time flag protection and
// wait/stop sequencing. Assumes an AXI4-Lite master, a CPU core that gives
// an instruction-boundary strobe, and peripherals that present live flags.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "silp_regs.svh"

// Operation
// R01: Global mask blocks all but software interrupt.
// R02: Lower priority number wins, 0 to 11.
// R03: Four hub sources share flag 2.
// R04: Hub endpoint transmit/receive share flag 3.
// R05: Device endpoint sources share flag 4.
// R06: Timer, keyboard, loop sources priorities 5-11.
// R07: First status shows flags 1-6, bits 1:0 zero.
// R08: Second status shows flags 7-11.
// R09: Third status always reads zero.
// R10: Resets equal, highest, never arbitrated.
// R11: Break forces software interrupt vector.
// R12: Break protects flags unless clear-enable set.
// R13: Two-step clears blocked during break only.
// R14: Wait or stop clears global mask.
// R15: Wait stops CPU clock; interrupt wakes.
// R16: Reset or break ends wait; break sets flag.
// R17: Watchdog keeps counting in wait unless disabled.
// R18: Stop resets counter, gates all clocks.
// R19: Stop exits on interrupt, reset, break.
// R20: Recovery 4096 crystal cycles, or 32 short.
// R21: Counter held until recovery, then times it.
// R22: Crystal systems should keep short recovery off.
// R23: Latched request holds until serviced or unmasked; the code drops it when the global mask is set.
// R24: Requests checked at instruction end, enabled only.
// R25: Status register writes are ignored.
module silp_ctrl
  import silp_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // AXI4-Lite slave.
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Peripheral flags in priority order 1 to 11, hub and endpoints split.
  input wire logic [16:0] i_src_flags,
  // CPU core.
  input wire logic i_global_mask,
  input wire logic i_instr_done,
  input wire logic i_swi_exec,
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic i_vec_taken,
  input wire logic i_brk_req,
  input wire logic i_xclk,
  // Outputs to CPU, clocks and peripherals.
  output logic o_irq_req,
  output logic [3:0] o_irq_vec,
  output logic o_brk_vec,
  output logic o_clear_mask,
  output logic o_cpu_clk_en,
  output logic o_sys_clk_en,
  output logic o_xclk_en,
  output logic o_wdog_run,
  output logic o_flag_clear_ok,
  output logic [11:0] o_flags
);

  silp_state_t s_ff;
  silp_state_t nxt_s;

  logic [11:0] req;
  logic [11:0] pend;
  logic [3:0] best;
  logic any_pend;
  logic xclk_fall;
  logic [12:0] rec_len;
  logic wr_fire;
  logic rd_take;

  // Per-source enable gating, then hub and endpoint sources merged.
  logic [16:0] gated;
  genvar g;
  generate
    for (g = 0; g < `SILP_NUM_SRC; g++) begin : g_gate
      assign gated[g] = i_src_flags[g] & s_ff.enables[g];
    end
  endgenerate

  always_comb begin
    req = 12'h000;
    req[1] = gated[0];
    req[2] = |gated[4:1]; // see R03
    req[3] = |gated[6:5]; // see R04
    req[4] = |gated[9:7]; // see R05
    req[11:5] = gated[16:10]; // see R06
    pend = req;
    // Smallest index wins, scanning down from the lowest priority.
    best = 4'h0;
    any_pend = 1'b0;
    for (int i = 11; i >= 1; i--) begin
      if (pend[i]) begin
        best = i[3:0]; // see R02
        any_pend = 1'b1;
      end
    end
  end

  // Falling crystal edge counts when the second stage has gone low while the third is still high.
  assign xclk_fall = s_ff.xclk_sync[2] & ~s_ff.xclk_sync[1];
  assign rec_len = s_ff.short_recovery_option ? `SILP_REC_SHORT_XCLK
                              : `SILP_REC_LONG_XCLK; // see R20 R22
  assign wr_fire = s_ff.aw_got[0] & s_ff.aw_got[1] & ~s_ff.bvalid;
  assign rd_take = i_arvalid & ~s_ff.rvalid;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.xclk_sync = {s_ff.xclk_sync[1:0], i_xclk};
    nxt_s.flags = {req[11:1], 1'b0};
    nxt_s.clear_mask = 1'b0;
    nxt_s.brk_vec = 1'b0;

    // Interrupt latch: once taken it holds until serviced or the global mask is set.
    if (s_ff.latched_valid) begin
      if (i_vec_taken || i_global_mask) begin
        nxt_s.latched_valid = 1'b0; // see R23
      end
    end else if (i_instr_done && !i_global_mask && any_pend) begin
      nxt_s.latched_valid = 1'b1; // see R01 R24
      nxt_s.latched_vec = best;
    end
    if (i_swi_exec) begin
      nxt_s.latched_valid = 1'b1; // see R01
      nxt_s.latched_vec = 4'h0;
    end

    case (s_ff.mode)
      SILP_RUN: begin
        if (i_brk_req) begin
          nxt_s.brk_vec = 1'b1; // see R11
          nxt_s.latched_valid = 1'b1;
          nxt_s.latched_vec = 4'h0;
        end else if (i_stop_exec) begin
          nxt_s.mode = SILP_STOP;
          nxt_s.clear_mask = 1'b1; // see R14
          nxt_s.rec_cnt = 13'h0000; // see R18 R21
        end else if (i_wait_exec) begin
          nxt_s.mode = SILP_WAIT;
          nxt_s.clear_mask = 1'b1; // see R14
        end
      end
      SILP_WAIT: begin
        if (i_brk_req) begin
          nxt_s.mode = SILP_RUN;
          nxt_s.break_exited_lowpower_flag = 1'b1; // see R16
          nxt_s.brk_vec = 1'b1;
        end else if (any_pend) begin
          nxt_s.mode = SILP_RUN; // see R15
          nxt_s.latched_valid = 1'b1;
          nxt_s.latched_vec = best;
        end
      end
      SILP_STOP: begin
        nxt_s.rec_cnt = 13'h0000; // see R21
        if (i_brk_req || any_pend) begin
          nxt_s.mode = SILP_RECOVER; // see R19
          nxt_s.rec_is_brk = i_brk_req;
        end
      end
      SILP_RECOVER: begin
        if (xclk_fall) begin
          nxt_s.rec_cnt = s_ff.rec_cnt + 13'h0001; // see R21
        end
        if (s_ff.rec_cnt >= rec_len) begin
          nxt_s.mode = SILP_RUN; // see R19 R20
          if (s_ff.rec_is_brk) begin
            nxt_s.break_exited_lowpower_flag = 1'b1; // see R19
            nxt_s.brk_vec = 1'b1;
          end else if (any_pend) begin
            nxt_s.latched_valid = 1'b1;
            nxt_s.latched_vec = best;
          end
        end
      end
      default: begin
        nxt_s.mode = SILP_RUN;
      end
    endcase

    nxt_s.cpu_clk_en = (nxt_s.mode == SILP_RUN); // see R15
    // Bus clocks stay off through recovery so the oscillator can settle.
    nxt_s.sys_clk_en = (nxt_s.mode != SILP_STOP) &&
                       (nxt_s.mode != SILP_RECOVER); // see R18 R19
    nxt_s.xclk_en = (nxt_s.mode != SILP_STOP); // see R18
    nxt_s.wdog_run = (nxt_s.mode == SILP_RUN) ||
                     (nxt_s.mode == SILP_WAIT && !s_ff.watchdog_disable_option); // see R17
    // Outside break clears always work; in break only with clear-enable.
    // Peripherals apply this per access, so a first step taken before break
    // still needs its second step to land while this is high.
    nxt_s.flag_clear_ok = !i_brk_req || s_ff.break_clear_enable; // see R12 R13
    nxt_s.irq_req = nxt_s.latched_valid;

    // Register bus: write address and data taken in either order.
    if (i_awvalid && !s_ff.aw_got[0] && !s_ff.bvalid) begin
      nxt_s.aw_got[0] = 1'b1;
      nxt_s.awaddr = i_awaddr;
    end
    if (i_wvalid && !s_ff.aw_got[1] && !s_ff.bvalid) begin
      nxt_s.aw_got[1] = 1'b1;
      nxt_s.wdata = i_wdata;
    end
    if (wr_fire) begin
      nxt_s.aw_got = 2'b00;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = 2'b00;
      case (s_ff.awaddr)
        // Status registers ignore writes; flags follow sources only.
        `SILP_OFF_FLAGS_LOW, `SILP_OFF_FLAGS_HIGH,
        `SILP_OFF_FLAGS_SPARE, `SILP_OFF_STATUS: begin
          nxt_s.bresp = 2'b00; // see R25
        end
        `SILP_OFF_BREAK_STATE: begin
          // A break exit in the same cycle as the clear wins only while the flag is still clear; a set flag is cleared.
          if (!s_ff.wdata[`SILP_BIT_BREAK_EXITED_LOWPOWER_FLAG] && (nxt_s.break_exited_lowpower_flag == s_ff.break_exited_lowpower_flag)) begin
            nxt_s.break_exited_lowpower_flag = 1'b0;
          end
        end
        `SILP_OFF_BREAK_FLAG_CTRL: begin
          nxt_s.break_clear_enable = s_ff.wdata[`SILP_BIT_BREAK_CLEAR_ENABLE];
        end
        `SILP_OFF_OPTIONS: begin
          nxt_s.short_recovery_option = s_ff.wdata[`SILP_BIT_SHORT_RECOVERY_OPTION];
          nxt_s.watchdog_disable_option = s_ff.wdata[`SILP_BIT_WATCHDOG_DISABLE_OPTION];
        end
        `SILP_OFF_ENABLES: begin
          nxt_s.enables = s_ff.wdata[16:0];
        end
        default: begin
          nxt_s.bresp = 2'b10;
        end
      endcase
    end
    if (s_ff.bvalid && i_bready) begin
      nxt_s.bvalid = 1'b0;
    end

    if (rd_take) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = 2'b00;
      nxt_s.rdata = 32'h0000_0000;
      case (i_araddr)
        `SILP_OFF_FLAGS_LOW: begin
          nxt_s.rdata[7:0] = {s_ff.flags[6:1], 2'b00}; // see R07
        end
        `SILP_OFF_FLAGS_HIGH: begin
          nxt_s.rdata[4:0] = s_ff.flags[11:7]; // see R08
        end
        `SILP_OFF_FLAGS_SPARE: begin
          nxt_s.rdata[7:0] = 8'h00; // see R09
        end
        `SILP_OFF_BREAK_STATE: begin
          nxt_s.rdata[`SILP_BIT_BREAK_EXITED_LOWPOWER_FLAG] = s_ff.break_exited_lowpower_flag;
        end
        `SILP_OFF_BREAK_FLAG_CTRL: begin
          nxt_s.rdata[`SILP_BIT_BREAK_CLEAR_ENABLE] = s_ff.break_clear_enable;
        end
        `SILP_OFF_OPTIONS: begin
          nxt_s.rdata[`SILP_BIT_SHORT_RECOVERY_OPTION] = s_ff.short_recovery_option;
          nxt_s.rdata[`SILP_BIT_WATCHDOG_DISABLE_OPTION] = s_ff.watchdog_disable_option;
        end
        `SILP_OFF_ENABLES: begin
          nxt_s.rdata[16:0] = s_ff.enables;
        end
        `SILP_OFF_STATUS: begin
          nxt_s.rdata[1:0] = s_ff.mode;
          nxt_s.rdata[14:2] = s_ff.rec_cnt;
        end
        default: begin
          nxt_s.rresp = 2'b10;
        end
      endcase
    end
    if (s_ff.rvalid && i_rready) begin
      nxt_s.rvalid = 1'b0;
    end
  end

  // Every reset source arrives merged on i_rst and wins over everything.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s_ff <= '0; // see R10
      s_ff.enables <= `SILP_ENABLES_RST;
      s_ff.cpu_clk_en <= 1'b1;
      s_ff.sys_clk_en <= 1'b1;
      s_ff.xclk_en <= 1'b1;
      s_ff.wdog_run <= 1'b1;
      s_ff.flag_clear_ok <= 1'b1;
      s_ff.xclk_sync <= 3'b000;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_awready = i_awvalid & ~s_ff.aw_got[0] & ~s_ff.bvalid;
  assign o_wready = i_wvalid & ~s_ff.aw_got[1] & ~s_ff.bvalid;
  assign o_arready = rd_take;
  assign o_bvalid = s_ff.bvalid;
  assign o_bresp = s_ff.bresp;
  assign o_rvalid = s_ff.rvalid;
  assign o_rdata = s_ff.rdata;
  assign o_rresp = s_ff.rresp;
  assign o_irq_req = s_ff.irq_req;
  assign o_irq_vec = s_ff.latched_vec;
  assign o_brk_vec = s_ff.brk_vec;
  assign o_clear_mask = s_ff.clear_mask;
  assign o_cpu_clk_en = s_ff.cpu_clk_en;
  assign o_sys_clk_en = s_ff.sys_clk_en;
  assign o_xclk_en = s_ff.xclk_en;
  assign o_wdog_run = s_ff.wdog_run;
  assign o_flag_clear_ok = s_ff.flag_clear_ok;
  assign o_flags = s_ff.flags;

endmodule : silp_ctrl

/* testbench/silp_ctrl_monitor.sv */
// Checker for the interrupt and low-power controller.
// Assumes it is bound to silp_ctrl and sees only its ports.
`timescale 1ns/1ps
module silp_ctrl_monitor (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // CPU side.
  input wire logic i_global_mask,
  input wire logic i_instr_done,
  input wire logic i_swi_exec,
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic i_vec_taken,
  input wire logic i_brk_req,
  // Watched outputs.
  input wire logic o_irq_req,
  input wire logic [3:0] o_irq_vec,
  input wire logic o_brk_vec,
  input wire logic o_clear_mask,
  input wire logic o_cpu_clk_en,
  input wire logic o_sys_clk_en,
  input wire logic o_xclk_en,
  input wire logic [11:0] o_flags
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  AST_MASK: assert property (i_global_mask && !i_brk_req && !i_swi_exec
    |=> !o_irq_req)
    else $error("request under mask");
  AST_ENTRY: assert property ($rose(o_irq_req) |-> $past(i_instr_done ||
    i_brk_req || i_swi_exec || !o_cpu_clk_en))
    else $error("request off a boundary");
  AST_HOLD: assert property (o_irq_req && !i_vec_taken && !i_global_mask
    && !i_brk_req && !i_swi_exec |=> o_irq_req && $stable(o_irq_vec))
    else $error("latched request changed");
  AST_WAIT: assert property (i_wait_exec |=> !o_cpu_clk_en && o_sys_clk_en)
    else $error("wait clocks wrong");
  AST_STOP: assert property (i_stop_exec |=> !o_sys_clk_en && !o_xclk_en)
    else $error("stop clocks wrong");
  AST_CLR: assert property (i_wait_exec || i_stop_exec |=> o_clear_mask)
    else $error("mask not cleared");
  AST_BRK: assert property ($rose(i_brk_req) |-> ##[1:3] o_brk_vec)
    else $error("no break vector");
  AST_F0: assert property (o_flags[0] == 1'h0)
    else $error("flag zero set");
endmodule : silp_ctrl_monitor
bind silp_ctrl silp_ctrl_monitor u_mon (.*);

/* testbench/silp_cpu_model.sv */
// CPU core model: instruction boundaries and vector fetches.
// Assumes the controller's request and CPU clock enable as inputs.
`timescale 1ns/1ps
module silp_cpu_model (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst,
  // From the controller.
  input wire logic i_irq_req,
  input wire logic i_cpu_clk_en,
  // To the controller.
  output logic o_instr_done,
  output logic o_vec_taken
);
  logic [2:0] cnt_ff;
  always_ff @(posedge i_mclk) begin
    cnt_ff <= i_rst ? 3'h0 : cnt_ff + 3'h1;
    // A halted CPU ends no instructions.
    o_instr_done <= !i_rst && i_cpu_clk_en && cnt_ff[1:0] == 2'h3;
    // Late fetch, so the latched number can be watched.
    o_vec_taken <= !i_rst && i_irq_req && cnt_ff == 3'h7;
  end
endmodule : silp_cpu_model

/* testbench/tb_top.sv */
// Self-checking bench for the interrupt and low-power controller.
// Assumes the CPU model beside it and registers over AXI4-Lite.
`timescale 1ns/1ps
`include "silp_regs.svh"
module tb_top;
  logic i_mclk = 1'h0, i_rst = 1'h1, i_xclk = 1'h0;
  logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata, d;
  logic [3:0] i_wstrb = 4'hF, o_irq_vec;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
  logic i_arvalid = 1'h0, i_rready = 1'h0, i_global_mask = 1'h0;
  logic i_swi_exec = 1'h0, i_wait_exec = 1'h0, i_stop_exec = 1'h0;
  logic i_brk_req = 1'h0, i_instr_done, i_vec_taken;
  logic [16:0] i_src_flags = 17'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq_req;
  logic o_brk_vec, o_clear_mask, o_cpu_clk_en, o_sys_clk_en, o_xclk_en;
  logic o_wdog_run, o_flag_clear_ok;
  logic [1:0] o_bresp, o_rresp, rr;
  logic [11:0] o_flags, e;
  int n_errors = 0, n_compared = 0, xf = 0, t, x;
  always #2 i_mclk = ~i_mclk;
  // Off the bus clock grid, so crystal edges meet a bus clock edge only once every 102 ns.
  always #5.1 i_xclk = ~i_xclk;
  always @(negedge i_xclk) xf++;
  silp_ctrl DUT (.*);
  silp_cpu_model u_cpu (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_irq_req(o_irq_req), .i_cpu_clk_en(o_cpu_clk_en),
    .o_instr_done(i_instr_done), .o_vec_taken(i_vec_taken));
  function automatic int prio(input int i);
    return i == 0 ? 1 : i < 5 ? 2 : i < 7 ? 3 : i < 10 ? 4 : i - 5;
  endfunction : prio
  task automatic close_out;
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] w);
    n_compared++;
    if (g !== w) begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, w);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(posedge i_mclk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end while (!o_bvalid);
    i_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      @(posedge i_mclk);
      if (o_arready) i_arvalid <= 1'h0;
    end while (!o_rvalid);
    d = o_rdata;
    rr = o_rresp;
    i_rready <= 1'h0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] v);
    rd(a);
    chk(d, v);
  endtask : rc
  // Bounded wait on a level; a timeout shows as a mismatch.
  task automatic till(ref logic s, input logic v);
    t = 0;
    while (s !== v && t < 20000) begin
      @(posedge i_mclk);
      t++;
    end
    chk({31'h0, s}, {31'h0, v});
  endtask : till
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc
  initial begin
    #300000;
    n_errors++;
    close_out();
  end
  initial begin
    cyc(8);
    i_rst <= 1'h0;
    rc(`SILP_OFF_ENABLES, 32'h1FFFF);
    rc(`SILP_OFF_FLAGS_SPARE, 32'h0);
    rd(8'h40);
    chk({30'h0, rr}, 32'h2);
    for (int i = 0; i < 17; i++) begin
      e = 12'h1 << prio(i);
      i_src_flags <= 17'h1 << i;
      cyc(3);
      chk({20'h0, o_flags}, {20'h0, e});
      wr(`SILP_OFF_FLAGS_LOW, 32'hFFFFFFFF);
      rc(`SILP_OFF_FLAGS_LOW, {24'h0, e[6:1], 2'h0});
      rc(`SILP_OFF_FLAGS_HIGH, {27'h0, e[11:7]});
    end
    wr(`SILP_OFF_ENABLES, 32'h0);
    i_src_flags <= 17'h00008;
    cyc(12);
    chk({19'h0, o_irq_req, o_flags}, 32'h0);
    wr(`SILP_OFF_ENABLES, 32'h1FFFF);
    i_global_mask <= 1'h1;
    i_src_flags <= 17'h10020;
    cyc(12);
    chk({31'h0, o_irq_req}, 32'h0);
    i_global_mask <= 1'h0;
    till(o_irq_req, 1'h1);
    chk({28'h0, o_irq_vec}, 32'h3);
    i_src_flags <= 17'h10021;
    cyc(2);
    chk({28'h0, o_irq_vec}, 32'h3);
    for (int k = 0; k < 2; k++) begin
      i_src_flags <= 17'h0;
      cyc(12);
      i_wait_exec <= 1'h1;
      cyc(1);
      i_wait_exec <= 1'h0;
      cyc(2);
      chk({30'h0, o_cpu_clk_en, o_wdog_run}, 32'h1);
      if (k == 0) i_src_flags <= 17'h01000;
      else i_brk_req <= 1'h1;
      till(o_cpu_clk_en, 1'h1);
    end
    chk({31'h0, o_flag_clear_ok}, 32'h0);
    wr(`SILP_OFF_BREAK_FLAG_CTRL, 32'h1);
    cyc(2);
    chk({31'h0, o_flag_clear_ok}, 32'h1);
    i_brk_req <= 1'h0;
    wr(`SILP_OFF_BREAK_FLAG_CTRL, 32'h0);
    rd(`SILP_OFF_BREAK_STATE);
    chk({31'h0, d[`SILP_BIT_BREAK_EXITED_LOWPOWER_FLAG]}, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(`SILP_OFF_OPTIONS, {31'h0, k == 0});
      i_stop_exec <= 1'h1;
      cyc(1);
      i_stop_exec <= 1'h0;
      cyc(2);
      chk({30'h0, o_sys_clk_en, o_xclk_en}, 32'h0);
      xf = 0;
      x = k == 0 ? 32 : 4096;
      i_src_flags <= 17'h00400;
      till(o_sys_clk_en, 1'h1);
      chk({31'h0, xf >= x && xf <= x + 4}, 32'h1);
      i_src_flags <= 17'h0;
      cyc(12);
    end
    i_swi_exec <= 1'h1;
    cyc(1);
    i_swi_exec <= 1'h0;
    till(o_irq_req, 1'h1);
    chk({28'h0, o_irq_vec}, 32'h0);
    close_out();
  end
endmodule : tb_top
